//--- rtl/dmsp_pkg.sv
package dmsp_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADR_PTR0_LO = 8'h82;
    localparam logic [7:0] ADR_PTR0_HI = 8'h83;
    localparam logic [7:0] ADR_PTR1_LO = 8'h84;
    localparam logic [7:0] ADR_PTR1_HI = 8'h85;
    localparam logic [7:0] ADR_PTR_SEL = 8'h86;
    localparam logic [7:0] ADR_TIMING = 8'h8E;

    // ==========================================================
    // Reset values and field positions
    localparam logic [2:0] STRETCH_RST = 3'h1;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic SEL_RST = 1'b0;
    localparam int STRETCH_LSB = 0;
    localparam int SEL_BIT = 0;

    // ==========================================================
    // Timing counts in clocks or machine cycles, and the on-chip SRAM bounds
    localparam int CLKS_PER_MC = 4;
    localparam int BASE_MC = 2;
    localparam int STROBE_S0 = 2;
    localparam int SETUP_S0 = 4;
    localparam int SETUP_EXTRA = 1;
    localparam int ALE_CLKS = 2;
    localparam int ADDR_CLKS = 3;
    localparam logic [15:0] SRAM_TOP = 16'h03FF;
    localparam int SRAM_WORDS = 1024;

    // ==========================================================
    // Access sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_INT = 3'b010,
        ST_EXT = 3'b100
    } dmsp_state_t;

    // Total clocks of one data move for a given stretch.
    function automatic logic [5:0] acc_clks(input logic [2:0] s);
        acc_clks = 6'(CLKS_PER_MC * (BASE_MC + int'(s)));
    endfunction : acc_clks

    // First clock of the read or write strobe.
    function automatic logic [5:0] strobe_first(input logic [2:0] s);
        strobe_first = (s == 3'h0) ? 6'(SETUP_S0) : 6'(SETUP_S0 + SETUP_EXTRA);
    endfunction : strobe_first

    // Clock just after the last strobe clock.
    function automatic logic [5:0] strobe_after(input logic [2:0] s);
        strobe_after = (s == 3'h0) ? 6'(SETUP_S0 + STROBE_S0)
            : 6'(SETUP_S0 + SETUP_EXTRA + CLKS_PER_MC * int'(s));
    endfunction : strobe_after

endpackage : dmsp_pkg

//--- rtl/dmsp_regs.sv
`timescale 1ns/100ps
// ==========================================================
// Data pointer pair, pointer select and access timing control.
module dmsp_regs (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic ptr_load_i,
    input wire logic [15:0] ptr_val_i,
    input wire logic ptr_inc_i,
    output logic [15:0] ptr_o,
    output logic [2:0] stretch_o,
    output logic [7:0] rdata_o
);
    logic [15:0] ptr0_ff, nxt_ptr0;
    logic [15:0] ptr1_ff, nxt_ptr1;
    logic sel_ff, nxt_sel;
    logic [2:0] stretch_ff, nxt_stretch;

    // Next values for register writes and pointer operations.
    always_comb begin
        nxt_ptr0 = ptr0_ff;
        nxt_ptr1 = ptr1_ff;
        nxt_sel = sel_ff;
        nxt_stretch = stretch_ff;
        if (sfr_wr_i) begin
            case (sfr_addr_i)
                dmsp_pkg::ADR_PTR0_LO: nxt_ptr0[7:0] = sfr_wdata_i;
                dmsp_pkg::ADR_PTR0_HI: nxt_ptr0[15:8] = sfr_wdata_i;
                dmsp_pkg::ADR_PTR1_LO: nxt_ptr1[7:0] = sfr_wdata_i;
                dmsp_pkg::ADR_PTR1_HI: nxt_ptr1[15:8] = sfr_wdata_i;
                dmsp_pkg::ADR_PTR_SEL: nxt_sel = sfr_wdata_i[dmsp_pkg::SEL_BIT];
                dmsp_pkg::ADR_TIMING: nxt_stretch =
                    sfr_wdata_i[dmsp_pkg::STRETCH_LSB +: 3];
                default: nxt_sel = sel_ff;
            endcase
        end
        // Load and increment act only on the selected pointer.
        if (ptr_load_i || ptr_inc_i) begin
            if (sel_ff) begin
                nxt_ptr1 = ptr_load_i ? ptr_val_i : ptr1_ff + 16'h0001;
            end else begin
                nxt_ptr0 = ptr_load_i ? ptr_val_i : ptr0_ff + 16'h0001;
            end
        end
    end

    // Register the state.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ptr0_ff <= dmsp_pkg::PTR_RST;
            ptr1_ff <= dmsp_pkg::PTR_RST;
            sel_ff <= dmsp_pkg::SEL_RST;
            stretch_ff <= dmsp_pkg::STRETCH_RST;
        end else begin
            ptr0_ff <= nxt_ptr0;
            ptr1_ff <= nxt_ptr1;
            sel_ff <= nxt_sel;
            stretch_ff <= nxt_stretch;
        end
    end

    // Selected pointer, stretch and the register read view.
    always_comb begin
        ptr_o = sel_ff ? ptr1_ff : ptr0_ff;
        stretch_o = stretch_ff;
        case (sfr_addr_i)
            dmsp_pkg::ADR_PTR0_LO: rdata_o = ptr0_ff[7:0];
            dmsp_pkg::ADR_PTR0_HI: rdata_o = ptr0_ff[15:8];
            dmsp_pkg::ADR_PTR1_LO: rdata_o = ptr1_ff[7:0];
            dmsp_pkg::ADR_PTR1_HI: rdata_o = ptr1_ff[15:8];
            dmsp_pkg::ADR_PTR_SEL: rdata_o = {7'h00, sel_ff};
            dmsp_pkg::ADR_TIMING: rdata_o = {5'h00, stretch_ff};
            default: rdata_o = 8'h00;
        endcase
    end
endmodule : dmsp_regs

//--- rtl/dmsp_sync.sv
`timescale 1ns/100ps
// ==========================================================
// Three-stage synchroniser for pin inputs.
module dmsp_sync #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] sync_o,
    output logic stable_o
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;

    // Only the second stage reads the first; later logic sees stages two/three.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= pin_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // A value counts once the second and third stages agree.
    assign sync_o = s3_ff;
    assign stable_o = (s2_ff == s3_ff);
endmodule : dmsp_sync

//--- rtl/dmsp_top.sv
`timescale 1ns/100ps
// ==========================================================
// Data move sequencer with stretch timing, on-chip data SRAM and
// the multiplexed external bus.
module dmsp_top (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic ptr_load_i,
    input wire logic [15:0] ptr_val_i,
    input wire logic ptr_inc_i,
    input wire logic sram_en_i,
    input wire logic acc_req_i,
    input wire logic acc_we_i,
    input wire logic [7:0] acc_wdata_i,
    output logic [7:0] acc_rdata_o,
    output logic acc_done_o,
    output logic acc_busy_o,
    output logic ale_o,
    output logic rd_n_o,
    output logic wr_n_o,
    input wire logic [7:0] low_address_data_port_i,
    output logic [7:0] low_address_data_port_o,
    output logic low_address_data_port_oe_o,
    output logic [7:0] high_address_port_o
);
    // ==========================================================
    // Register file

    logic [15:0] sel_ptr;
    logic [2:0] stretch_cfg;
    logic [7:0] reg_rdata;

    dmsp_regs u_regs (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .sfr_addr_i(sfr_addr_i),
        .sfr_wdata_i(sfr_wdata_i),
        .sfr_wr_i(sfr_wr_i),
        .ptr_load_i(ptr_load_i),
        .ptr_val_i(ptr_val_i),
        .ptr_inc_i(ptr_inc_i),
        .ptr_o(sel_ptr),
        .stretch_o(stretch_cfg),
        .rdata_o(reg_rdata)
    );

    // ==========================================================
    // Pin input synchroniser

    logic [7:0] bus_in_sync;
    logic bus_in_stable;

    dmsp_sync #(
        .W(8)
    ) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .pin_i(low_address_data_port_i),
        .sync_o(bus_in_sync),
        .stable_o(bus_in_stable)
    );

    // ==========================================================
    // On-chip data SRAM

    logic [7:0] sram_mem [dmsp_pkg::SRAM_WORDS];
    logic [7:0] sram_q_ff;
    logic sram_we;
    // Latched move address and write data, shared with the sequencer.
    logic [15:0] addr_ff, nxt_addr;
    logic [7:0] wdata_ff, nxt_wdata;

    // The array has no reset; the read port follows the latched address.
    always_ff @(posedge clk_i) begin
        if (sram_we) begin
            sram_mem[addr_ff[9:0]] <= wdata_ff;
        end
        sram_q_ff <= sram_mem[addr_ff[9:0]];
    end

    // ==========================================================
    // Access sequencer state

    dmsp_pkg::dmsp_state_t state_ff, nxt_state;
    logic [5:0] cnt_ff, nxt_cnt;
    logic [5:0] len_ff, nxt_len;
    logic [2:0] str_ff, nxt_str;
    logic we_ff, nxt_we;
    logic [7:0] rdata_ff, nxt_rdata;
    logic done_ff, nxt_done;
    logic last_cnt;
    logic hits_sram;

    // An address decodes internal only while the SRAM is enabled.
    assign hits_sram = sram_en_i && (sel_ptr <= dmsp_pkg::SRAM_TOP);
    assign last_cnt = (cnt_ff == len_ff - 6'h01);
    assign sram_we = (state_ff == dmsp_pkg::ST_INT) && we_ff
        && (cnt_ff == 6'h00);

    // Next-state logic for the move sequencer.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_len = len_ff;
        nxt_str = str_ff;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_we = we_ff;
        nxt_rdata = rdata_ff;
        nxt_done = 1'b0;
        case (state_ff)
            dmsp_pkg::ST_IDLE: begin
                if (acc_req_i) begin
                    // The address always comes from the selected pointer.
                    nxt_addr = sel_ptr;
                    nxt_we = acc_we_i;
                    nxt_wdata = acc_wdata_i;
                    nxt_cnt = 6'h00;
                    // The newest stretch is caught at the start of each move.
                    nxt_str = stretch_cfg;
                    if (hits_sram) begin
                        nxt_state = dmsp_pkg::ST_INT;
                        nxt_len = dmsp_pkg::acc_clks(3'h0);
                    end else begin
                        nxt_state = dmsp_pkg::ST_EXT;
                        nxt_len = dmsp_pkg::acc_clks(stretch_cfg);
                    end
                end
            end
            dmsp_pkg::ST_INT: begin
                if (last_cnt) begin
                    nxt_state = dmsp_pkg::ST_IDLE;
                    nxt_done = 1'b1;
                    nxt_cnt = 6'h00;
                    if (!we_ff) begin
                        nxt_rdata = sram_q_ff;
                    end
                end else begin
                    nxt_cnt = cnt_ff + 6'h01;
                end
            end
            dmsp_pkg::ST_EXT: begin
                if (last_cnt) begin
                    nxt_state = dmsp_pkg::ST_IDLE;
                    nxt_done = 1'b1;
                    nxt_cnt = 6'h00;
                    // Read data is taken from the agreed synchroniser stages.
                    if (!we_ff && bus_in_stable) begin
                        nxt_rdata = bus_in_sync;
                    end
                end else begin
                    nxt_cnt = cnt_ff + 6'h01;
                end
            end
            default: begin
                nxt_state = dmsp_pkg::ST_IDLE;
                nxt_cnt = 6'h00;
            end
        endcase
    end

    // Register the sequencer state.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= dmsp_pkg::ST_IDLE;
            cnt_ff <= 6'h00;
            len_ff <= 6'h00;
            str_ff <= dmsp_pkg::STRETCH_RST;
            addr_ff <= 16'h0000;
            wdata_ff <= 8'h00;
            we_ff <= 1'b0;
            rdata_ff <= 8'h00;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            len_ff <= nxt_len;
            str_ff <= nxt_str;
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
            we_ff <= nxt_we;
            rdata_ff <= nxt_rdata;
            done_ff <= nxt_done;
        end
    end

    // ==========================================================
    // External bus pins

    logic nxt_ale, ale_ff;
    logic nxt_rd_n, rd_n_ff;
    logic nxt_wr_n, wr_n_ff;
    logic [7:0] nxt_p0, p0_ff;
    logic nxt_p0_oe, p0_oe_ff;
    logic [7:0] nxt_p2, p2_ff;
    logic [7:0] nxt_sfr_rd, sfr_rd_ff;
    logic in_ext;
    logic strobe_on;

    // Pin levels follow the next count so that pins and count line up.
    // Program fetches never pass through this sequencer.
    always_comb begin
        in_ext = (nxt_state == dmsp_pkg::ST_EXT);
        // Strobe window: setup and hold each gain a clock above stretch zero.
        strobe_on = in_ext
            && (nxt_cnt >= dmsp_pkg::strobe_first(nxt_str))
            && (nxt_cnt < dmsp_pkg::strobe_after(nxt_str));
        nxt_ale = in_ext && (nxt_cnt < 6'(dmsp_pkg::ALE_CLKS));
        nxt_rd_n = !(strobe_on && !nxt_we);
        nxt_wr_n = !(strobe_on && nxt_we);
        // Low address first, then write data on the same port.
        nxt_p0_oe = in_ext
            && ((nxt_cnt < 6'(dmsp_pkg::ADDR_CLKS)) || nxt_we);
        nxt_p0 = (nxt_cnt < 6'(dmsp_pkg::ADDR_CLKS)) ? nxt_addr[7:0]
            : nxt_wdata;
        nxt_p2 = nxt_addr[15:8];
        nxt_sfr_rd = sfr_rd_i ? reg_rdata : sfr_rd_ff;
    end

    // Register the pins and the register read port.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ale_ff <= 1'b0;
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
            p0_ff <= 8'h00;
            p0_oe_ff <= 1'b0;
            p2_ff <= 8'h00;
            sfr_rd_ff <= 8'h00;
        end else begin
            ale_ff <= nxt_ale;
            rd_n_ff <= nxt_rd_n;
            wr_n_ff <= nxt_wr_n;
            p0_ff <= nxt_p0;
            p0_oe_ff <= nxt_p0_oe;
            p2_ff <= nxt_p2;
            sfr_rd_ff <= nxt_sfr_rd;
        end
    end

    // Outputs come straight from flip-flops; busy is decoded from the state.
    assign ale_o = ale_ff;
    assign rd_n_o = rd_n_ff;
    assign wr_n_o = wr_n_ff;
    assign low_address_data_port_o = p0_ff;
    assign low_address_data_port_oe_o = p0_oe_ff;
    assign high_address_port_o = p2_ff;
    assign sfr_rdata_o = sfr_rd_ff;
    assign acc_rdata_o = rdata_ff;
    assign acc_done_o = done_ff;
    assign acc_busy_o = (state_ff != dmsp_pkg::ST_IDLE);
endmodule : dmsp_top

//--- verification/dmsp_ext_ram.sv
`timescale 1ns/100ps
// ==========================================================
// Behavioural external data RAM on the multiplexed bus.
module dmsp_ext_ram (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ale_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [7:0] bus_i,
    input wire logic [7:0] high_i,
    output logic drv_o,
    output logic [7:0] dat_o,
    output logic [15:0] addr_o
);
    logic [7:0] mem [256];
    logic [1:0] hold_ff;

    // Latches the address and stores write data up to the strobe end.
    always @(posedge clk_i) begin
        if (ale_i) begin
            addr_o <= {high_i, bus_i};
        end
        if (!wr_n_i) begin
            mem[addr_o[7:0] ^ addr_o[15:8]] <= bus_i;
        end
    end

    // Holds read data three clocks past the strobe, then lets go.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hold_ff <= 2'h0;
        end else begin
            hold_ff <= !rd_n_i ? 2'h3 : hold_ff - (hold_ff != 2'h0);
        end
    end
    assign drv_o = !rd_n_i || hold_ff != 2'h0;
    assign dat_o = mem[addr_o[7:0] ^ addr_o[15:8]];
endmodule : dmsp_ext_ram

//--- verification/dmsp_props.sv
`timescale 1ns/100ps
// ==========================================================
// Move, bus timing and register read checks seen at the top ports.
module dmsp_props (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic acc_req_i,
    input wire logic acc_we_i,
    input wire logic [7:0] acc_wdata_i,
    input wire logic acc_done_o,
    input wire logic acc_busy_o,
    input wire logic ale_o,
    input wire logic rd_n_o,
    input wire logic wr_n_o,
    input wire logic [7:0] low_address_data_port_o,
    input wire logic low_address_data_port_oe_o
);
    logic [5:0] cnt_ff, nxt_cnt, exp_n, first, after;
    logic [2:0] str_ff, nxt_str, sl_ff, nxt_sl;
    logic [7:0] wd_ff, nxt_wd;
    logic run_ff, nxt_run, we_ff, nxt_we, ext_ff, ext, take, strb, act;

    // Shadows the stretch, latches each move and counts its cycles.
    always_comb begin
        take = acc_req_i && !acc_busy_o;
        nxt_str = str_ff;
        if (sfr_wr_i && sfr_addr_i == dmsp_pkg::ADR_TIMING) begin
            nxt_str = sfr_wdata_i[2:0];
        end
        nxt_run = take || (run_ff && !acc_done_o);
        nxt_cnt = take ? 6'h00 : cnt_ff + 6'h01;
        nxt_sl = take ? str_ff : sl_ff;
        nxt_we = take ? acc_we_i : we_ff;
        nxt_wd = take ? acc_wdata_i : wd_ff;
        ext = (cnt_ff == 6'h00) ? ale_o : ext_ff;
        exp_n = ext ? {1'b0, sl_ff, 2'b00} + 6'h08 : 6'h08;
        first = (sl_ff == 3'h0) ? 6'h04 : 6'h05;
        after = (sl_ff == 3'h0) ? 6'h06 : {1'b0, sl_ff, 2'b00} + 6'h05;
        strb = cnt_ff >= first && cnt_ff < after;
        act = run_ff && ext && cnt_ff < exp_n;
    end

    // Registers the shadow state.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {run_ff, we_ff, ext_ff, cnt_ff, wd_ff, sl_ff} <= '0;
            str_ff <= 3'h1;
        end else begin
            {run_ff, we_ff, ext_ff} <= {nxt_run, nxt_we, ext};
            {cnt_ff, wd_ff, sl_ff, str_ff} <= {nxt_cnt, nxt_wd, nxt_sl, nxt_str};
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_done_count: assert property (
        acc_done_o |-> run_ff && cnt_ff == exp_n)
        else $error("done at wrong cycle");
    a_busy_span: assert property (
        run_ff && cnt_ff > 6'h00 && cnt_ff < exp_n |-> acc_busy_o)
        else $error("busy dropped inside a move");
    a_done_pulse: assert property (
        acc_done_o |=> !acc_done_o)
        else $error("done longer than one cycle");
    a_strobe_shape: assert property (
        act |-> rd_n_o == !(!we_ff && strb) && wr_n_o == !(we_ff && strb))
        else $error("strobe placement wrong");
    a_ale_pulse: assert property (
        act |-> ale_o == (cnt_ff < 6'h02))
        else $error("latch enable placement wrong");
    a_port_drive: assert property (
        act |-> low_address_data_port_oe_o == (cnt_ff < 6'h03 || we_ff))
        else $error("port drive window wrong");
    a_write_data: assert property (
        act && we_ff && cnt_ff > 6'h02 |-> low_address_data_port_o == wd_ff)
        else $error("write data wrong on port");
    a_int_quiet: assert property (
        run_ff && !ext |-> !ale_o && rd_n_o && wr_n_o
            && !low_address_data_port_oe_o)
        else $error("bus active on internal move");
    a_idle_quiet: assert property (
        !run_ff |-> !ale_o && rd_n_o && wr_n_o)
        else $error("bus active without a move");
    a_sel_read: assert property (
        sfr_rd_i && sfr_addr_i == dmsp_pkg::ADR_PTR_SEL
            |=> sfr_rdata_o[7:1] == 7'h00)
        else $error("select upper bits not zero");
    a_str_read: assert property (
        sfr_rd_i && sfr_addr_i == dmsp_pkg::ADR_TIMING
            |=> sfr_rdata_o == {5'h00, $past(str_ff)})
        else $error("stretch read wrong");
endmodule : dmsp_props

bind dmsp_top dmsp_props u_props (
    .clk_i(clk_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o), .acc_req_i(acc_req_i), .acc_we_i(acc_we_i),
    .acc_wdata_i(acc_wdata_i), .acc_done_o(acc_done_o),
    .acc_busy_o(acc_busy_o), .ale_o(ale_o), .rd_n_o(rd_n_o),
    .wr_n_o(wr_n_o), .low_address_data_port_o(low_address_data_port_o),
    .low_address_data_port_oe_o(low_address_data_port_oe_o)
);

//--- verification/tb_top.sv
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench: registers, pointers and data moves.
module tb_top;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00;
    logic [7:0] acc_wdata_i = 8'h00, last_ff = 8'h00;
    logic [15:0] ptr_val_i = 16'h0000;
    logic sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, ptr_load_i = 1'b0;
    logic ptr_inc_i = 1'b0, sram_en_i = 1'b0, acc_req_i = 1'b0;
    logic acc_we_i = 1'b0, sel = 1'b0;
    logic [7:0] sfr_rdata_o, acc_rdata_o, p0_o, p2_o, m_dat, bus, r, v;
    logic acc_done_o, acc_busy_o, ale_o, rd_n_o, wr_n_o, p0_oe, m_drv;
    logic [15:0] m_addr, pb, ptr [2];
    logic [31:0] w, seed = 32'h138d_b976;
    int s, num_errors = 0, compares = 0;
    logic [7:0] ra [7] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h8e, 8'h80};
    logic [7:0] rm [7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h01, 8'h07, 8'h00};
    logic [7:0] vals [7];
    logic [15:0] ba [3] = '{16'h03ff, 16'h0400, 16'h0000};

    // Free-running clock of 40 ns.
    always #20 clk_i = ~clk_i;

    // Port 0 wire: the driver wins, else the level flips when released.
    assign bus = p0_oe ? p0_o : (m_drv ? m_dat : ~last_ff);
    always @(posedge clk_i) last_ff <= bus;

    dmsp_top DUT (
        .clk_i(clk_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
        .sfr_rdata_o(sfr_rdata_o), .ptr_load_i(ptr_load_i),
        .ptr_val_i(ptr_val_i), .ptr_inc_i(ptr_inc_i), .sram_en_i(sram_en_i),
        .acc_req_i(acc_req_i), .acc_we_i(acc_we_i), .acc_wdata_i(acc_wdata_i),
        .acc_rdata_o(acc_rdata_o), .acc_done_o(acc_done_o),
        .acc_busy_o(acc_busy_o), .ale_o(ale_o), .rd_n_o(rd_n_o),
        .wr_n_o(wr_n_o), .low_address_data_port_i(bus),
        .low_address_data_port_o(p0_o), .low_address_data_port_oe_o(p0_oe),
        .high_address_port_o(p2_o)
    );
    dmsp_ext_ram u_ram (
        .clk_i(clk_i), .rstn_i(rstn_i), .ale_i(ale_o), .rd_n_i(rd_n_o),
        .wr_n_i(wr_n_o), .bus_i(bus), .high_i(p2_o), .drv_o(m_drv),
        .dat_o(m_dat), .addr_o(m_addr)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [15:0] exp_clks(int st, logic ext);
        return ext ? 16'(4 * (2 + st)) : 16'h0008;
    endfunction : exp_clks

    function automatic logic [15:0] exp_wid(int st, logic ext);
        return !ext ? 16'h0000 : (st == 0 ? 16'h0002 : 16'(4 * st));
    endfunction : exp_wid

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        {sfr_addr_i, sfr_wdata_i, sfr_wr_i} = {a, d, 1'b1};
        @(negedge clk_i);
        sfr_wr_i = 1'b0;
        @(negedge clk_i);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        {sfr_addr_i, sfr_rd_i} = {a, 1'b1};
        @(negedge clk_i);
        sfr_rd_i = 1'b0;
        @(negedge clk_i);
        d = sfr_rdata_o;
    endtask : reg_rd

    task automatic set_ptr(input logic [15:0] a, input logic inc);
        {ptr_val_i, ptr_load_i, ptr_inc_i} = {a, !inc, inc};
        ptr[sel] = inc ? ptr[sel] + 16'h0001 : a;
        @(negedge clk_i);
        {ptr_load_i, ptr_inc_i} = 2'b00;
        @(negedge clk_i);
    endtask : set_ptr

    task automatic mv(input logic we, input logic [7:0] d);
        int n, k;
        logic [15:0] a;
        logic ext;
        {a, n, k} = {ptr[sel], 32'h0, 32'h0};
        ext = !sram_en_i || a > 16'h03ff;
        {acc_req_i, acc_we_i, acc_wdata_i} = {1'b1, we, d};
        @(negedge clk_i);
        acc_req_i = 1'b0;
        while (acc_done_o !== 1'b1) begin
            k += (rd_n_o === 1'b0 || wr_n_o === 1'b0);
            n++;
            if (n > 60) begin
                num_errors++;
                give_verdict();
            end
            @(negedge clk_i);
        end
        check(16'(n), exp_clks(s, ext));
        check(16'(k), exp_wid(s, ext));
        if (ext) check(m_addr, a);
        if (!we) check({8'h00, acc_rdata_o}, {8'h00, d});
    endtask : mv

    // Main sequence, inputs driven at the falling edge.
    initial begin
        repeat (10) @(negedge clk_i);
        rstn_i = 1'b1;
        for (int i = 0; i < 7; i++) begin
            reg_rd(ra[i], r);
            check(r, i == 5 ? 16'h0001 : 16'h0000);
        end
        s = 1;
        w = rnd();
        set_ptr(w[15:0] | 16'h8000, 1'b0);
        mv(1'b1, w[23:16]);
        mv(1'b0, w[23:16]);
        for (int i = 0; i < 7; i++) begin
            w = rnd();
            vals[i] = w[7:0];
            reg_wr(ra[i], w[7:0]);
            reg_rd(ra[i], r);
            check(r, w[7:0] & rm[i]);
        end
        ptr[0] = {vals[1], vals[0]};
        ptr[1] = {vals[3], vals[2]};
        sel = vals[4][0];
        s = vals[5][2:0];
        reg_rd(8'h86, r);
        reg_wr(8'h86, r + 8'h01);
        sel = ~sel;
        set_ptr(16'h0000, 1'b1);
        w = rnd();
        set_ptr(w[15:0], 1'b0);
        for (int i = 0; i < 4; i++) begin
            reg_rd(ra[i], r);
            pb = ptr[i / 2];
            check(r, i % 2 ? pb[15:8] : pb[7:0]);
        end
        for (s = 0; s < 8; s++) begin
            v = rnd();
            reg_wr(8'h8e, {v[7:3], 3'(s)});
            reg_wr(8'h86, v);
            {sel, sram_en_i} = {v[0], v[1]};
            w = rnd();
            set_ptr(w[15:0], 1'b0);
            mv(1'b1, w[23:16]);
            mv(1'b0, w[23:16]);
        end
        s = 7;
        for (int i = 0; i < 3; i++) begin
            sram_en_i = (i < 2);
            set_ptr(ba[i], 1'b0);
            w = rnd();
            mv(1'b1, w[7:0]);
            mv(1'b0, w[7:0]);
        end
        reg_wr(8'h8e, 8'h02);
        s = 2;
        fork
            mv(1'b1, 8'h5a);
            begin
                repeat (4) @(negedge clk_i);
                reg_wr(8'h8e, 8'h06);
            end
        join
        s = 6;
        mv(1'b0, 8'h5a);
        give_verdict();
    end
endmodule : tb_top
